// ### src/iec_capture.sv
// Input edge capture unit with register port and interrupt
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "iec_cfg.svh"

// Summary of operation
// - Enabled unit captures according to the selected capture mode.
// - Disabled unit is idle, raises no interrupts, settings writable.
// - Idle-stop set halts the unit during processor Idle.
// - First-edge select, used only in mode 110, picks rising or falling.
// - Wide-capture set stores 32-bit timer value, else 16-bit.
// - Interrupt after every 1st, 2nd, 3rd or 4th capture event.
// - Read-only overflow flag shows that a capture was lost.
// - Read-only buffer-not-empty flag shows unread captured values.
// - Mode 110 captures every edge, starting with the selected edge.
// - Mode 100 captures on every fourth rising edge.
// - Mode 011 captures on every rising edge.
// - Mode 010 captures on every falling edge.
// - Mode 001 captures on every edge, rising and falling.
// - Mode 000 captures nothing.
module iec_capture import iec_pkg::*; (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	input  wire logic        cap_in,
	input  wire logic [31:0] timer_first,
	input  wire logic [31:0] timer_second,
	input  wire logic        cpu_idle,
	input  wire logic        cpu_sleep,
	output logic             irq
);
	iec_ctrl_t   ctrl_q;
	iec_ctrl_t   ctrl_d;
	iec_evt_t    stat_q;
	iec_evt_t    ien_q;
	iec_evt_t    evt_set;
	iec_evt_t    evt_clr;
	iec_state_t  st_q;
	logic        pin_q;
	logic [3:0]  pre_q;
	logic [1:0]  div_q;
	logic        ovf_q;
	logic        irq_q;
	logic [31:0] rdata_q;
	logic        rise;
	logic        fall;
	logic        active;
	logic        cap_ev;
	logic        div_hit;
	logic        irq_only_ev;
	logic [31:0] cap_word;
	logic [15:0] narrow;
	logic        fifo_full;
	logic        fifo_empty;
	logic [31:0] fifo_head;
	logic        buf_pop;
	logic        wr_ctrl;
	logic        wr_clr;
	logic        wr_ien;
	logic [31:0] ctrl_rd;
	logic [31:0] rd_mux;
	logic        pre_last;
	logic        first_hit;

	// ----------------------------------------------------
	// Register decode
	// ----------------------------------------------------
	assign wr_ctrl = reg_wr & (reg_addr == `IEC_OFF_CTRL);
	assign wr_clr  = reg_wr & (reg_addr == `IEC_OFF_CLR);
	assign wr_ien  = reg_wr & (reg_addr == `IEC_OFF_IEN);
	assign buf_pop = reg_rd & (reg_addr == `IEC_OFF_BUF);

	// settings locked while on
	// Only the enable bit moves while running, so modes never glitch
	always_comb begin
		ctrl_d    = ctrl_q;
		ctrl_d.on = reg_wdata[`IEC_B_ON];
		if (!ctrl_q.on) begin
			ctrl_d.idle_stop           = reg_wdata[`IEC_B_IDLE];
			ctrl_d.first_edge_select   = reg_wdata[`IEC_B_FIRST_EDGE_SELECT];
			ctrl_d.wide_capture        = reg_wdata[`IEC_B_WIDE];
			ctrl_d.timer_source_select = reg_wdata[`IEC_B_TSEL];
			ctrl_d.interrupt_divisor   =
				reg_wdata[`IEC_B_DIV_HI:`IEC_B_DIV_LO];
			ctrl_d.capture_mode        =
				reg_wdata[`IEC_B_MODE_HI:`IEC_B_MODE_LO];
		end
	end

	// Readback of capture_control with live status bits
	always_comb begin
		ctrl_rd = 32'h0;
		ctrl_rd[`IEC_B_ON]    = ctrl_q.on;
		ctrl_rd[`IEC_B_IDLE]  = ctrl_q.idle_stop;
		ctrl_rd[`IEC_B_FIRST_EDGE_SELECT] = ctrl_q.first_edge_select;
		ctrl_rd[`IEC_B_WIDE]  = ctrl_q.wide_capture;
		ctrl_rd[`IEC_B_TSEL]  = ctrl_q.timer_source_select;
		ctrl_rd[`IEC_B_DIV_HI:`IEC_B_DIV_LO] =
			ctrl_q.interrupt_divisor;
		ctrl_rd[`IEC_B_OVF]   = ovf_q;
		ctrl_rd[`IEC_B_BNE]   = ~fifo_empty;
		ctrl_rd[`IEC_B_MODE_HI:`IEC_B_MODE_LO] =
			ctrl_q.capture_mode;
	end

	// Read mux; unmapped and write-only offsets read as zero
	always_comb begin
		unique case (reg_addr)
			`IEC_OFF_CTRL: rd_mux = ctrl_rd;
			`IEC_OFF_BUF:  rd_mux = fifo_head;
			`IEC_OFF_STAT: rd_mux = {30'h0, stat_q};
			`IEC_OFF_IEN:  rd_mux = {30'h0, ien_q};
			default:       rd_mux = 32'h0;
		endcase
	end

	// ----------------------------------------------------
	// Edge detection and event selection
	// ----------------------------------------------------
	// idle halt
	assign active = ctrl_q.on & ~(ctrl_q.idle_stop & cpu_idle);
	assign rise   = cap_in & ~pin_q;
	assign fall   = ~cap_in & pin_q;

	assign pre_last = (ctrl_q.capture_mode == `IEC_M_PRE4) ?
		(pre_q == `IEC_PRE4_LAST) : (pre_q == `IEC_PRE16_LAST);

	assign first_hit = ctrl_q.first_edge_select ? rise : fall;

	always_comb begin
		unique case (ctrl_q.capture_mode)
			`IEC_M_EDGE:  cap_ev = rise | fall;
			`IEC_M_FALL:  cap_ev = fall;
			`IEC_M_RISE:  cap_ev = rise;
			`IEC_M_PRE4,
			`IEC_M_PRE16: cap_ev = rise & pre_last;
			`IEC_M_EVERY: cap_ev = (st_q == IEC_WAIT_FIRST) ?
				first_hit : (rise | fall);
			`IEC_M_OFF,
			`IEC_M_IRQ:   cap_ev = 1'b0;
		endcase
		cap_ev = cap_ev & active;
	end

	// wake interrupt in low power only
	assign irq_only_ev = active & (rise | fall) &
		(ctrl_q.capture_mode == `IEC_M_IRQ) & (cpu_idle | cpu_sleep);

	assign narrow   = ctrl_q.timer_source_select ?
		timer_first[15:0] : timer_second[15:0];
	assign cap_word = ctrl_q.wide_capture ? timer_first :
		{16'h0, narrow};

	assign div_hit = cap_ev & (div_q == ctrl_q.interrupt_divisor);

	// ----------------------------------------------------
	// Capture state
	// ----------------------------------------------------
	// Pin history, prescaler, divisor and first-edge tracker
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_q <= 1'b0;
			pre_q <= '0;
			div_q <= '0;
			st_q  <= IEC_WAIT_FIRST;
		end else begin
			pin_q <= cap_in;
			if (~ctrl_q.on) begin
				pre_q <= '0;
				div_q <= '0;
				st_q  <= IEC_WAIT_FIRST;
			end else begin
				if (active & rise)
					pre_q <= pre_last ? 4'h0 : pre_q + 4'h1;
				if (cap_ev)
					div_q <= div_hit ? 2'h0 : div_q + 2'h1;
				if (cap_ev)
					st_q <= IEC_ALL_EDGES;
			end
		end
	end

	iec_capture_fifo u_fifo (
		.clk       (clk),
		.reset     (reset),
		.flush     (~ctrl_q.on),
		.push      (cap_ev),
		.push_data (cap_word),
		.pop       (buf_pop),
		.head      (fifo_head),
		.full      (fifo_full),
		.empty     (fifo_empty)
	);

	// ----------------------------------------------------
	// Interrupt events
	// ----------------------------------------------------
	// events need the unit on
	assign evt_set.cap = div_hit | irq_only_ev;
	assign evt_set.ovf = cap_ev & fifo_full;
	assign evt_clr     = reg_wdata[`IEC_S_OVF:`IEC_S_CAP] & {2{wr_clr}};

	// Registers, sticky status; a new event beats a clear
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q  <= '0;
			ien_q   <= '0;
			stat_q  <= '0;
			ovf_q   <= 1'b0;
			irq_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_q <= ctrl_d;
			if (wr_ien)
				ien_q <= reg_wdata[`IEC_S_OVF:`IEC_S_CAP];
			stat_q  <= (stat_q & ~evt_clr) | evt_set;
			// overflow sticks until the unit is switched off
			ovf_q   <= ctrl_q.on & (ovf_q | evt_set.ovf);
			irq_q   <= |(stat_q & ien_q);
			rdata_q <= reg_rd ? rd_mux : 32'h0;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = irq_q;

	// ----------------------------------------------------
	// Checks
	// ----------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	chk_off_no_event: assert property (
		!ctrl_q.on |-> !cap_ev && !evt_set.cap && !evt_set.ovf)
		else $error("event while unit off");
	chk_idle_halt: assert property (
		ctrl_q.idle_stop && cpu_idle |-> !cap_ev)
		else $error("capture while halted in idle");
	chk_mode_off: assert property (
		ctrl_q.capture_mode == `IEC_M_OFF |=> $stable(u_fifo.wr_q))
		else $error("capture in disabled mode");
	chk_rise_capture: assert property (
		active && ctrl_q.capture_mode == `IEC_M_RISE && rise
		|-> cap_ev)
		else $error("rising edge not captured");
	chk_pre4_gap: assert property (
		active && ctrl_q.capture_mode == `IEC_M_PRE4 && rise
		&& pre_q != `IEC_PRE4_LAST |-> !cap_ev)
		else $error("prescaled capture too early");
	chk_wide_word: assert property (
		cap_ev && !ctrl_q.wide_capture |-> cap_word[31:16] == 16'h0)
		else $error("narrow capture carries upper bits");
	chk_bne_flag: assert property (
		cap_ev && !fifo_full && !wr_ctrl ##1 !reg_rd
		|=> ctrl_rd[`IEC_B_BNE])
		else $error("buffer flag not set after capture");
	chk_ovf_flag: assert property (
		ctrl_q.on && cap_ev && fifo_full && !wr_ctrl
		|=> ##1 ovf_q)
		else $error("overflow not flagged");
	chk_irq_level: assert property (
		|(stat_q & ien_q) |=> irq)
		else $error("interrupt output not raised");
	chk_lowpower_irq: assert property (
		irq_only_ev |-> cpu_idle || cpu_sleep)
		else $error("interrupt-only event outside low power");
	chk_fall_capture: assert property (
		active && ctrl_q.capture_mode == `IEC_M_FALL && fall
		|-> cap_ev)
		else $error("falling edge not captured");
	chk_edge_capture: assert property (
		active && ctrl_q.capture_mode == `IEC_M_EDGE && (rise || fall)
		|-> cap_ev)
		else $error("edge not captured");
	chk_first_edge: assert property (
		active && ctrl_q.capture_mode == `IEC_M_EVERY
		&& st_q == IEC_WAIT_FIRST && !first_hit |-> !cap_ev)
		else $error("capture before the selected first edge");
	chk_ctrl_locked: assert property (
		ctrl_q.on && wr_ctrl
		|=> ctrl_q.capture_mode == $past(ctrl_q.capture_mode))
		else $error("mode changed while unit on");
	chk_wide_source: assert property (
		cap_ev && ctrl_q.wide_capture |-> cap_word == timer_first)
		else $error("wide capture not from first timer");
	chk_div_every: assert property (
		cap_ev && !(|ctrl_q.interrupt_divisor) |=> stat_q.cap)
		else $error("capture event did not set status");

endmodule // iec_capture

// ### src/iec_capture_fifo.sv
// Buffer of captured timer words
`timescale 1ns/1ps
`include "iec_cfg.svh"

module iec_capture_fifo import iec_pkg::*; (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        flush,
	input  wire logic        push,
	input  wire logic [31:0] push_data,
	input  wire logic        pop,
	output logic [31:0]      head,
	output logic             full,
	output logic             empty
);
	logic [31:0]           mem [`IEC_FIFO_DEPTH];
	logic [`IEC_PTR_W-1:0] wr_q;
	logic [`IEC_PTR_W-1:0] rd_q;
	logic [2:0]            cnt_q;
	logic                  do_push;
	logic                  do_pop;

	// ----------------------------------------------------
	// Flags and handshakes
	// ----------------------------------------------------
	// A push into a full buffer is dropped; the caller flags it
	assign full    = (cnt_q == `IEC_CNT_FULL);
	assign empty   = (cnt_q == 3'h0);
	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;
	assign head    = mem[rd_q];

	// Storage has no reset, only pointers and fill count do
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_q] <= push_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk) begin
		if (reset | flush) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_q + {1'b0, do_push};
			rd_q  <= rd_q + {1'b0, do_pop};
			cnt_q <= cnt_q + {2'h0, do_push} - {2'h0, do_pop};
		end
	end

endmodule // iec_capture_fifo

// ### src/iec_cfg.svh
// Offsets, field positions, codes and sizes of the edge capture unit
`ifndef IEC_CFG_SVH
`define IEC_CFG_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define IEC_OFF_CTRL    8'h00
`define IEC_OFF_BUF     8'h04
`define IEC_OFF_STAT    8'h08
`define IEC_OFF_CLR     8'h0c
`define IEC_OFF_IEN     8'h10

// ------------------------------------------------------------
// Field positions in capture_control
// ------------------------------------------------------------
`define IEC_B_ON        15
`define IEC_B_IDLE      13
`define IEC_B_FIRST_EDGE_SELECT     9
`define IEC_B_WIDE      8
`define IEC_B_TSEL      7
`define IEC_B_DIV_HI    6
`define IEC_B_DIV_LO    5
`define IEC_B_OVF       4
`define IEC_B_BNE       3
`define IEC_B_MODE_HI   2
`define IEC_B_MODE_LO   0

// Status, clear and enable bit positions
`define IEC_S_CAP       0
`define IEC_S_OVF       1

// ------------------------------------------------------------
// Capture mode codes
// ------------------------------------------------------------
`define IEC_M_OFF       3'h0
`define IEC_M_EDGE      3'h1
`define IEC_M_FALL      3'h2
`define IEC_M_RISE      3'h3
`define IEC_M_PRE4      3'h4
`define IEC_M_PRE16     3'h5
`define IEC_M_EVERY     3'h6
`define IEC_M_IRQ       3'h7

// ------------------------------------------------------------
// Counts and sizes
// ------------------------------------------------------------
`define IEC_PRE4_LAST   4'h3
`define IEC_PRE16_LAST  4'hf
`define IEC_FIFO_DEPTH  4
`define IEC_PTR_W       2
`define IEC_CNT_FULL    3'h4

`endif

// ### src/iec_pkg.sv
// Types shared by the edge capture unit
package iec_pkg;

	// Software control fields of capture_control
	typedef struct packed {
		logic       on;
		logic       idle_stop;
		logic       first_edge_select;
		logic       wide_capture;
		logic       timer_source_select;
		logic [1:0] interrupt_divisor;
		logic [2:0] capture_mode;
	} iec_ctrl_t;

	// Sticky event flags
	typedef struct packed {
		logic ovf;
		logic cap;
	} iec_evt_t;

	// Progress through the every-edge mode
	typedef enum logic {
		IEC_WAIT_FIRST,
		IEC_ALL_EDGES
	} iec_state_t;

endpackage

// ### testbench/iec_capture_bench.sv
// Self-checking bench for the edge capture unit
`timescale 1ns/1ps
`include "iec_cfg.svh"

module iec_capture_bench import iec_pkg::*;;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        cpu_idle = 1'b0;
	logic        cpu_sleep = 1'b0;
	logic        run = 1'b0;
	logic        level = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] timer_first;
	logic [31:0] timer_second;
	logic [31:0] rv;
	logic        cap_in;
	logic        irq;
	logic [15:0] cnt = 16'h0000;
	logic [31:0] wc[3];
	logic [31:0] we[3];
	logic [31:0] mc[9] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h5,
		32'h6, 32'h206, 32'h7};
	int          mx[9] = '{0, 32, 16, 16, 4, 1, 31, 32, 0};
	int          err_total = 0;
	int          num_checks = 0;
	int          n;
	int          k;

	always #2.5 clk = ~clk;

	iec_capture i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cap_in(cap_in), .timer_first(timer_first),
		.timer_second(timer_second), .cpu_idle(cpu_idle),
		.cpu_sleep(cpu_sleep), .irq(irq));

	iec_source i_src (.clk(clk), .reset(reset), .run(run), .level(level),
		.cap_in(cap_in), .timer_first(timer_first),
		.timer_second(timer_second));

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task stop_test;
		if (err_total == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask

	// One pin edge, then time for buffer, status and irq to settle
	task flip;
		@(posedge clk);
		level <= ~level;
		repeat (4) @(posedge clk);
		#1;
	endtask

	task bump(input int c);
		@(posedge clk);
		run <= 1'b1;
		repeat (c) @(posedge clk);
		run <= 1'b0;
		cnt = cnt + c[15:0];
	endtask

	// Fields are only taken while off, so write them first, then enable
	task setup(input logic [31:0] c);
		wr(`IEC_OFF_CTRL, 32'h0);
		wr(`IEC_OFF_CTRL, c);
		wr(`IEC_OFF_CTRL, c | 32'h8000);
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rd(`IEC_OFF_CTRL);
		chk("control", 32'h0, rv);
		rd(8'h14);
		chk("unmapped", 32'h0, rv);
		bump(291);
		// Rising edges, first timer, masked then enabled interrupt
		setup(32'h83);
		wr(`IEC_OFF_CTRL, 32'h8001);
		rd(`IEC_OFF_CTRL);
		chk("control", 32'h8083, rv);
		flip;
		chk("irq", 32'h0, {31'h0, irq});
		rd(`IEC_OFF_CTRL);
		chk("control", 32'h808b, rv);
		wr(`IEC_OFF_IEN, 32'h1);
		rd(`IEC_OFF_BUF);
		chk("capture", {16'h0, cnt}, rv);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`IEC_OFF_CLR, 32'h1);
		rd(`IEC_OFF_STAT);
		chk("status", 32'h0, rv);
		chk("irq", 32'h0, {31'h0, irq});
		flip;
		rd(`IEC_OFF_CTRL);
		chk("control", 32'h8083, rv);
		// Width and timer choice on any edge
		wc = '{32'h101, 32'h001, 32'h181};
		we = '{{16'h7e5a, cnt}, {16'h0, cnt ^ 16'h8000}, {16'h7e5a, cnt}};
		for (n = 0; n < 3; n++) begin
			setup(wc[n]);
			flip;
			rd(`IEC_OFF_BUF);
			chk("capture", we[n], rv);
		end
		// Count captures over 16 pulses in every mode
		for (n = 0; n < 9; n++) begin
			setup(32'h0);
			if (level)
				flip;
			setup(mc[n]);
			k = 0;
			repeat (32) begin
				flip;
				rd(`IEC_OFF_CTRL);
				if (rv[3] === 1'b1) begin
					rd(`IEC_OFF_BUF);
					k++;
				end
			end
			chk("captures", mx[n], k);
		end
		// Divisor of four, then a fifth capture overflows the buffer
		wr(`IEC_OFF_CLR, 32'h3);
		setup(32'h61);
		wr(`IEC_OFF_IEN, 32'h3);
		repeat (3) flip;
		rd(`IEC_OFF_STAT);
		chk("status", 32'h0, rv);
		flip;
		chk("irq", 32'h1, {31'h0, irq});
		flip;
		rd(`IEC_OFF_CTRL);
		chk("control", 32'h8079, rv);
		rd(`IEC_OFF_STAT);
		chk("status", 32'h3, rv);
		wr(`IEC_OFF_CLR, 32'h3);
		wr(`IEC_OFF_CTRL, 32'h0);
		flip;
		rd(`IEC_OFF_CTRL);
		chk("control", 32'h61, rv);
		chk("irq", 32'h0, {31'h0, irq});
		// Idle stop, then interrupt-only mode during sleep
		setup(32'h2001);
		cpu_idle <= 1'b1;
		flip;
		rd(`IEC_OFF_CTRL);
		chk("control", 32'ha001, rv);
		setup(32'h1);
		flip;
		rd(`IEC_OFF_CTRL);
		chk("control", 32'h8009, rv);
		cpu_idle <= 1'b0;
		cpu_sleep <= 1'b1;
		setup(32'h7);
		wr(`IEC_OFF_CLR, 32'h3);
		flip;
		rd(`IEC_OFF_STAT);
		chk("status", 32'h1, rv);
		rd(`IEC_OFF_CTRL);
		chk("control", 32'h8007, rv);
		// Same mode awake: edges must not raise the event
		wr(`IEC_OFF_CLR, 32'h3);
		cpu_sleep <= 1'b0;
		flip;
		rd(`IEC_OFF_STAT);
		chk("status", 32'h0, rv);
		stop_test;
	end

	// Watchdog well beyond the few thousand cycles the tests need
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		stop_test;
	end
endmodule // iec_capture_bench

// ### testbench/iec_source.sv
// Partner model: capture pin driver and two frozen-or-running timers
`timescale 1ns/1ps

module iec_source (
	input  wire logic   clk,
	input  wire logic   reset,
	input  wire logic   run,
	input  wire logic   level,
	output logic        cap_in,
	output logic [31:0] timer_first,
	output logic [31:0] timer_second
);
	logic [15:0] cnt_q;

	// ------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------
	// Low halves differ so that a capture shows which timer was taken
	assign timer_first  = {16'h7e5a, cnt_q};
	assign timer_second = {16'h00b4, cnt_q ^ 16'h8000};

	// Pin follows the commanded level; timers hold still unless run
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q  <= 16'h0000;
			cap_in <= 1'b0;
		end else begin
			cap_in <= level;
			if (run)
				cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule // iec_source
